/* logic/boot_clk_map.vh */
// Purpose: Register map, encodings and counts for boot and clock select
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Included by boot_clock_ctrl.v and by both testbench files
//
// Function
// - Wait 1024 slow RC cycles before first fetch
// - Slow RC drives system clock until boot ends
// - Separate enables: crystal bit7, fast bit4, slow bit2
// - Slow RC on, crystal off after boot
// - 34h, 14h, 3Ch select fast RC /2, /4, /8
// - 1Ch, 7Ch fast /16, /32; E4h slow undivided
// - Writable fast RC trim, nominal 16MHz target
// - Build-time slow choice: E4h, fast off, watchdog on
// - Calibration disabled: reset value, slow clock, watchdog on
// - Fast divided choices: watchdog off, both RC running
// - Unit 0 starts at 000h, unit 1 at 001h
// - Interrupt vector 010h for unit 0 only
// - Unit 1 disabled after reset; software enables later
// - Valid clock mode write switches clock once the output is low
`ifndef BOOT_CLK_MAP_VH
`define BOOT_CLK_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CLKMD        12'h000
`define OFS_XTAL_CTRL    12'h004
`define OFS_TRIM         12'h008
`define OFS_UNIT_CTRL    12'h00C
`define OFS_STATUS       12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_XTAL_EN      7
`define BIT_FAST_EN      4
`define BIT_SLOW_EN      2
`define BIT_UNIT0_EN     0
`define BIT_UNIT1_EN     1
`define BIT_WDT_EN       2

// ----------------------------------------------------------------
// Clock mode encodings and reset values
// ----------------------------------------------------------------
`define CLKMD_FAST_D2    8'h34
`define CLKMD_FAST_D4    8'h14
`define CLKMD_FAST_D8    8'h3C
`define CLKMD_FAST_D16   8'h1C
`define CLKMD_FAST_D32   8'h7C
`define CLKMD_SLOW_D1    8'hE4
`define CLKMD_SEL_MASK   8'hEB
`define CLKMD_RST        8'hE4
`define XTAL_CTRL_RST    8'h00
`define TRIM_RST         8'h80
`define UNIT_CTRL_RST    3'h5

// Build-time calibration choices
`define CAL_FAST_D2      3'h0
`define CAL_FAST_D4      3'h1
`define CAL_FAST_D8      3'h2
`define CAL_FAST_D16     3'h3
`define CAL_FAST_D32     3'h4
`define CAL_SLOW         3'h5
`define CAL_DISABLE      3'h6

// Clock sources
`define SRC_SLOW         2'h0
`define SRC_FAST         2'h1
`define SRC_XTAL         2'h2

// ----------------------------------------------------------------
// Counts and addresses
// ----------------------------------------------------------------
`define BOOT_SLOW_CYCLES 1024
`define FAST_RC_TARGET_MHZ 16
`define UNIT0_RESET_PC   12'h000
`define UNIT1_RESET_PC   12'h001
`define UNIT0_INT_PC     12'h010

`endif

/* logic/boot_clock_ctrl.v */
// Purpose: Boot wait, unit release and system clock source selection
// Assumes: Oscillator outputs arrive as pins far slower than CLK_SYS
// Notes:   System clock out is rebuilt from sampled oscillator levels
`timescale 1ns/1ps
`include "boot_clk_map.vh"

module boot_clock_ctrl #(
    parameter       BOOT_CYCLES = `BOOT_SLOW_CYCLES,
    parameter [2:0] CAL_MODE    = `CAL_FAST_D16,
    parameter [7:0] CAL_TRIM    = `TRIM_RST
) (
    input  wire        CLK_SYS,          // 200 MHz system clock
    input  wire        RST_N,            // Power-on reset, sync, active low
    input  wire        PSEL,             // APB select
    input  wire        PENABLE,          // APB access phase
    input  wire        PWRITE,           // APB write
    input  wire [11:0] PADDR,            // APB byte address
    input  wire [31:0] PWDATA,           // APB write data
    output wire [31:0] PRDATA,           // APB read data
    output wire        PREADY,           // APB ready
    output wire        PSLVERR,          // APB error on unmapped address
    input  wire        SLOW_RC_CLK,      // Slow RC oscillator output
    input  wire        FAST_RC_CLK,      // Fast RC oscillator output
    input  wire        CRYSTAL_CLK,      // Crystal oscillator output
    output wire        SLOW_RC_EN,       // Slow RC oscillator enable
    output wire        FAST_RC_EN,       // Fast RC oscillator enable
    output wire        CRYSTAL_EN,       // Crystal oscillator enable
    output wire [7:0]  FAST_RC_TRIM,     // Fast RC frequency trim
    output wire        SYS_CLK_OUT,      // Selected and divided clock
    output wire        WDT_EN,           // Watchdog enable
    output wire        BOOT_DONE,        // Boot wait finished
    output wire        UNIT0_RUN,        // Unit 0 may fetch
    output wire        UNIT1_RUN,        // Unit 1 may fetch
    output wire [11:0] UNIT0_START_PC,   // Unit 0 start address
    output wire [11:0] UNIT1_START_PC,   // Unit 1 start address
    input  wire        IRQ_REQ,          // Interrupt request from peripherals
    output wire        UNIT0_INT_TAKE,   // Unit 0 takes interrupt
    output wire [11:0] UNIT0_INT_PC      // Unit 0 interrupt vector
);

    // ------------------------------------------------------------
    // Oscillator sampling and edge detection
    // ------------------------------------------------------------
    wire [2:0] osc_sync;
    reg  [2:0] osc_prev_r;
    wire [2:0] osc_rise;

    sync_2ff #(
        .WIDTH (3)
    ) u_osc_sync (
        .CLK_SYS (CLK_SYS),
        .RST_N   (RST_N),
        .D       ({CRYSTAL_CLK, FAST_RC_CLK, SLOW_RC_CLK}),
        .Q       (osc_sync)
    );

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            osc_prev_r <= 3'h0;
        end else begin
            osc_prev_r <= osc_sync;
        end
    end

    // Rising edges of the sampled oscillator levels
    assign osc_rise = osc_sync & ~osc_prev_r;

    // ------------------------------------------------------------
    // Boot wait
    // ------------------------------------------------------------
    reg [10:0] boot_cnt_r;
    reg        boot_done_r;
    wire       boot_end;

    assign boot_end = !boot_done_r && osc_rise[`SRC_SLOW] &&
                      (boot_cnt_r == BOOT_CYCLES[10:0] - 11'h001);

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            boot_cnt_r  <= 11'h000;
            boot_done_r <= 1'b0;
        end else if (boot_end) begin
            boot_done_r <= 1'b1;
        end else if (!boot_done_r && osc_rise[`SRC_SLOW]) begin
            boot_cnt_r  <= boot_cnt_r + 11'h001;
        end
    end

    // ------------------------------------------------------------
    // Clock mode decode
    // ------------------------------------------------------------
    // Returns {valid, source[1:0], half_divide[4:0]}; half 0 means /1
    // Enable bits are masked so a switch may keep the old oscillator on
    function [7:0] decode_clkmd;
        input [7:0] val;
        reg   [7:0] sel;
        begin
            sel = val & `CLKMD_SEL_MASK;
            case (sel)
                (`CLKMD_FAST_D2 & `CLKMD_SEL_MASK):  decode_clkmd = {1'b1, `SRC_FAST, 5'd1};
                (`CLKMD_FAST_D4 & `CLKMD_SEL_MASK):  decode_clkmd = {1'b1, `SRC_FAST, 5'd2};
                (`CLKMD_FAST_D8 & `CLKMD_SEL_MASK):  decode_clkmd = {1'b1, `SRC_FAST, 5'd4};
                (`CLKMD_FAST_D16 & `CLKMD_SEL_MASK): decode_clkmd = {1'b1, `SRC_FAST, 5'd8};
                (`CLKMD_FAST_D32 & `CLKMD_SEL_MASK): decode_clkmd = {1'b1, `SRC_FAST, 5'd16};
                (`CLKMD_SLOW_D1 & `CLKMD_SEL_MASK):  decode_clkmd = {1'b1, `SRC_SLOW, 5'd0};
                default:         decode_clkmd = 8'h00;
            endcase
        end
    endfunction

    // Clock mode loaded when boot ends, per build-time choice
    function [7:0] boot_clkmd;
        input [2:0] mode;
        begin
            case (mode)
                `CAL_FAST_D2:  boot_clkmd = `CLKMD_FAST_D2;
                `CAL_FAST_D4:  boot_clkmd = `CLKMD_FAST_D4;
                `CAL_FAST_D8:  boot_clkmd = `CLKMD_FAST_D8;
                `CAL_FAST_D16: boot_clkmd = `CLKMD_FAST_D16;
                `CAL_FAST_D32: boot_clkmd = `CLKMD_FAST_D32;
                `CAL_SLOW:     boot_clkmd = `CLKMD_SLOW_D1;
                default:       boot_clkmd = `CLKMD_RST;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    reg  [7:0]  clkmd_r;
    reg  [7:0]  xtal_ctrl_r;
    reg  [7:0]  trim_r;
    reg  [2:0]  unit_ctrl_r;
    reg  [31:0] prdata_r;
    reg  [31:0] prdata_nxt;
    reg         hit;
    wire        wr_acc;
    wire        rd_acc;
    wire        wr_clkmd;
    wire [7:0]  dec_wr;
    wire [7:0]  dec_boot;
    wire        fast_div_boot;
    wire [7:0]  status;

    assign wr_acc   = PSEL && PENABLE && PWRITE;
    assign rd_acc   = PSEL && PENABLE && !PWRITE;
    assign wr_clkmd = wr_acc && (PADDR == `OFS_CLKMD);
    assign dec_wr   = decode_clkmd(PWDATA[7:0]);
    assign dec_boot = decode_clkmd(boot_clkmd(CAL_MODE));
    assign fast_div_boot = (CAL_MODE <= `CAL_FAST_D32);

    // Address hit for the five mapped words
    always @* begin
        case (PADDR)
            `OFS_CLKMD, `OFS_XTAL_CTRL, `OFS_TRIM,
            `OFS_UNIT_CTRL, `OFS_STATUS: hit = 1'b1;
            default:                     hit = 1'b0;
        endcase
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            clkmd_r     <= `CLKMD_RST;
            xtal_ctrl_r <= `XTAL_CTRL_RST;
            trim_r      <= `TRIM_RST;
            unit_ctrl_r <= `UNIT_CTRL_RST;
        end else if (boot_end) begin
            // Boot load wins over a write in the same cycle
            clkmd_r <= boot_clkmd(CAL_MODE);
            if (CAL_MODE != `CAL_DISABLE) begin
                trim_r <= CAL_TRIM;
            end
            unit_ctrl_r[`BIT_WDT_EN] <= !fast_div_boot;
        end else if (wr_acc) begin
            case (PADDR)
                `OFS_CLKMD:     clkmd_r     <= PWDATA[7:0];
                `OFS_XTAL_CTRL: xtal_ctrl_r <= PWDATA[7:0];
                `OFS_TRIM:      trim_r      <= PWDATA[7:0];
                `OFS_UNIT_CTRL: unit_ctrl_r <= PWDATA[2:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always @* begin
        case (PADDR)
            `OFS_CLKMD:     prdata_nxt = {24'h000000, clkmd_r};
            `OFS_XTAL_CTRL: prdata_nxt = {24'h000000, xtal_ctrl_r};
            `OFS_TRIM:      prdata_nxt = {24'h000000, trim_r};
            `OFS_UNIT_CTRL: prdata_nxt = {29'h00000000, unit_ctrl_r};
            `OFS_STATUS:    prdata_nxt = {24'h000000, status};
            default:        prdata_nxt = 32'h00000000;
        endcase
    end

    // Read data registered in the setup cycle, held through access
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            prdata_r <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            prdata_r <= prdata_nxt;
        end
    end

    assign PRDATA  = prdata_r;
    assign PREADY  = 1'b1;
    assign PSLVERR = (wr_acc || rd_acc) && !hit;

    // ------------------------------------------------------------
    // Source selection and divider
    // ------------------------------------------------------------
    reg [1:0] sel_src_r;
    reg [4:0] sel_half_r;
    reg [1:0] req_src_r;
    reg [4:0] req_half_r;
    reg [4:0] div_cnt_r;
    reg       clk_out_r;
    reg       lvl_arm_r;
    wire      pending;
    wire      src_lvl;
    wire      src_rise;

    // A new request waits here until the output is low
    assign pending  = (req_src_r != sel_src_r) || (req_half_r != sel_half_r);
    assign src_lvl  = osc_sync[sel_src_r];
    assign src_rise = osc_rise[sel_src_r];

    // Requested selection follows valid writes and the boot load
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            req_src_r  <= `SRC_SLOW;
            req_half_r <= 5'd0;
        end else if (boot_end && dec_boot[7]) begin
            req_src_r  <= dec_boot[6:5];
            req_half_r <= dec_boot[4:0];
        end else if (wr_clkmd && dec_wr[7]) begin
            req_src_r  <= dec_wr[6:5];
            req_half_r <= dec_wr[4:0];
        end
    end

    // Switch only while output is low so no high pulse is cut short;
    // an undivided source is followed only after its next low phase
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sel_src_r  <= `SRC_SLOW;
            sel_half_r <= 5'd0;
            div_cnt_r  <= 5'd0;
            clk_out_r  <= 1'b0;
            lvl_arm_r  <= 1'b0;
        end else if (pending && !clk_out_r) begin
            sel_src_r  <= req_src_r;
            sel_half_r <= req_half_r;
            div_cnt_r  <= 5'd0;
            lvl_arm_r  <= 1'b0;
        end else if (sel_half_r == 5'd0) begin
            clk_out_r  <= src_lvl && lvl_arm_r;
            lvl_arm_r  <= lvl_arm_r || !src_lvl;
        end else if (src_rise) begin
            if (div_cnt_r == sel_half_r - 5'd1) begin
                div_cnt_r <= 5'd0;
                clk_out_r <= !clk_out_r;
            end else begin
                div_cnt_r <= div_cnt_r + 5'd1;
            end
        end
    end

    assign SYS_CLK_OUT = clk_out_r;

    // ------------------------------------------------------------
    // Status and outputs
    // ------------------------------------------------------------
    // Bit 7 watchdog, bits 6:2 half divider, bit 1 not slow, bit 0 boot done
    assign status[7]   = unit_ctrl_r[`BIT_WDT_EN];
    assign status[6:2] = sel_half_r;
    assign status[1]   = sel_src_r[0] | sel_src_r[1];
    assign status[0]   = boot_done_r;

    // Enables follow the raw register bits, reserved codes too
    assign SLOW_RC_EN   = clkmd_r[`BIT_SLOW_EN];
    assign FAST_RC_EN   = clkmd_r[`BIT_FAST_EN];
    assign CRYSTAL_EN   = xtal_ctrl_r[`BIT_XTAL_EN];
    assign FAST_RC_TRIM = trim_r;
    assign WDT_EN       = unit_ctrl_r[`BIT_WDT_EN];
    assign BOOT_DONE    = boot_done_r;

    assign UNIT0_RUN = boot_done_r && unit_ctrl_r[`BIT_UNIT0_EN];
    assign UNIT1_RUN = boot_done_r && unit_ctrl_r[`BIT_UNIT1_EN];
    assign UNIT0_START_PC = `UNIT0_RESET_PC;
    assign UNIT1_START_PC = `UNIT1_RESET_PC;

    // ------------------------------------------------------------
    // Interrupt entry
    // ------------------------------------------------------------
    // Unit 1 has no interrupt path at all
    assign UNIT0_INT_TAKE = IRQ_REQ && UNIT0_RUN;
    assign UNIT0_INT_PC   = `UNIT0_INT_PC;

endmodule

/* logic/sync_2ff.v */
// Purpose: Two-flop synchroniser for a group of unrelated levels
// Assumes: Each bit changes independently of the others
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps

module sync_2ff #(
    parameter WIDTH = 3
) (
    input  wire             CLK_SYS,   // System clock
    input  wire             RST_N,     // Synchronous reset, active low
    input  wire [WIDTH-1:0] D,         // Asynchronous levels
    output wire [WIDTH-1:0] Q          // Synchronised levels
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= D;
            sync_r <= meta_r;
        end
    end

    assign Q = sync_r;

endmodule

/* testbench/boot_and_system_clock_select_bench.sv */
// Purpose: Self-checking bench for boot wait and clock source selection
// Assumes: Oscillators free-run from counters, fast RC period 4 cycles, slow 8
// Notes:   Boot wait shortened to 8 slow cycles; reads checked from a queue
`timescale 1ns/1ps
`include "boot_clk_map.vh"

module boot_and_system_clock_select_bench;
    localparam int BOOT_CYC = 8;
    logic        clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_req = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, r;
    logic        slow_rc = 1'b0, fast_rc = 1'b0, xtal = 1'b0, s_prev = 1'b0, f_prev = 1'b0, y_prev = 1'b0;
    logic        meas_slow = 1'b0;
    logic [7:0]  tick = 8'h00, per_cnt = 8'h00, last_per = 8'h00, t;
    logic [32:0] rd_q[$], e;
    logic [7:0]  codes[6] = '{8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hF4};
    int          divs[6] = '{2, 4, 8, 16, 32, 1};
    int          miscompares = 0, compares = 0, cyc = 0, slow_rises = 0, per_seen = 0;
    wire [31:0]  prdata;
    wire [11:0]  pc0, pc1, int_pc;
    wire [7:0]   trim;
    wire         pready, pslverr, slow_en, fast_en, xtal_en, sys_clk, wdt_en, boot_done, run0, run1, int_take;
    wire         src_rise = meas_slow ? (slow_rc && !s_prev) : (fast_rc && !f_prev);

    boot_clock_ctrl #(.BOOT_CYCLES(BOOT_CYC), .CAL_MODE(3'h3), .CAL_TRIM(8'h80)) boot_clock_ctrl_i (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SLOW_RC_CLK(slow_rc), .FAST_RC_CLK(fast_rc), .CRYSTAL_CLK(xtal), .SLOW_RC_EN(slow_en),
        .FAST_RC_EN(fast_en), .CRYSTAL_EN(xtal_en), .FAST_RC_TRIM(trim), .SYS_CLK_OUT(sys_clk),
        .WDT_EN(wdt_en), .BOOT_DONE(boot_done), .UNIT0_RUN(run0), .UNIT1_RUN(run1),
        .UNIT0_START_PC(pc0), .UNIT1_START_PC(pc1), .IRQ_REQ(irq_req), .UNIT0_INT_TAKE(int_take),
        .UNIT0_INT_PC(int_pc));

    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Oscillators, period meter, read monitor and timeout
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        tick <= rst_n ? tick + 8'h01 : 8'h00;
        fast_rc <= tick[1];
        slow_rc <= tick[2];
        xtal <= tick[3];
        s_prev <= slow_rc;
        f_prev <= fast_rc;
        y_prev <= sys_clk;
        if (!rst_n)
            slow_rises <= 0;
        else if (slow_rc && !s_prev)
            slow_rises <= slow_rises + 1;
        if (sys_clk && !y_prev) begin
            per_cnt <= {7'h00, src_rise};
            last_per <= per_cnt;
            per_seen <= per_seen + 1;
        end else begin
            per_cnt <= per_cnt + {7'h00, src_rise};
        end
        if (psel && penable && pready && !pwrite) begin
            e = (rd_q.size() > 0) ? rd_q.pop_front() : 33'h1FFFFFFFF;
            chk(prdata, e[31:0]);
            chk({31'h0, pslverr}, {31'h0, e[32]});
        end
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr)
            rd_q.push_back(x);
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {1'b0, d});
    endtask

    task automatic period(input logic slow, input int n);
        int k;
        meas_slow = slow;
        k = per_seen;
        while (per_seen < k + 3 && cyc < 20000)
            @(posedge clk_sys);
        #1;
        chk({24'h0, last_per}, n);
    endtask

    // ----------------------------------------------------------------
    // Stimulus and checks
    // ----------------------------------------------------------------
    initial begin
        r = $urandom(95809);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`OFS_CLKMD, 32'hE4);
        rd(`OFS_XTAL_CTRL, 32'h00);
        rd(`OFS_UNIT_CTRL, 32'h05);
        chk({30'h0, run1, run0}, 32'h0);
        $display("test reset_values done");
        while (boot_done !== 1'b1 && cyc < 20000)
            @(posedge clk_sys);
        chk(slow_rises, BOOT_CYC);
        #1;
        chk({30'h0, run1, run0}, 32'h1);
        chk({28'h0, xtal_en, fast_en, slow_en, wdt_en}, 32'h6);
        rd(`OFS_CLKMD, 32'h1C);
        rd(`OFS_TRIM, 32'h80);
        period(1'b0, 16);
        $display("test boot done");
        chk({8'h0, pc0, pc1}, 32'h000001);
        chk({20'h0, int_pc}, 32'h010);
        repeat (8) begin
            @(posedge clk_sys);
            r = $urandom;
            irq_req <= r[0];
            #1;
            chk({31'h0, int_take}, {31'h0, irq_req});
        end
        $display("test start_and_interrupt done");
        foreach (codes[i]) begin
            wr(`OFS_CLKMD, {24'h0, codes[i]});
            rd(`OFS_CLKMD, {24'h0, codes[i]});
            period(codes[i] == 8'hF4, divs[i]);
        end
        wr(`OFS_CLKMD, 32'hE4);
        chk({31'h0, fast_en}, 32'h0);
        $display("test clock_modes done");
        wr(`OFS_CLKMD, 32'h55);
        rd(`OFS_CLKMD, 32'h55);
        period(1'b1, 1);
        wr(`OFS_CLKMD, 32'h14);
        period(1'b0, 4);
        wr(`OFS_CLKMD, 32'h96);
        period(1'b0, 4);
        $display("test reserved_codes done");
        r = $urandom;
        t = r[7:0];
        wr(`OFS_TRIM, {24'h0, t});
        chk({24'h0, trim}, {24'h0, t});
        rd(`OFS_TRIM, {24'h0, t});
        wr(`OFS_XTAL_CTRL, 32'h80);
        chk({31'h0, xtal_en}, 32'h1);
        wr(`OFS_UNIT_CTRL, 32'h03);
        chk({29'h0, run1, run0, wdt_en}, 32'h6);
        apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
        $display("test registers done");
        print_verdict();
    end
endmodule

/* testbench/boot_clock_ctrl_assertions.sv */
// Purpose: Concurrent checks on boot wait, unit release, enables and trim
// Assumes: Slow RC pin is far slower than CLK_SYS and starts low after reset
// Notes:   Bound into boot_clock_ctrl by the statement at the foot
`timescale 1ns/1ps
`include "boot_clk_map.vh"

module boot_clock_ctrl_chk #(
    parameter       BOOT_CYCLES = 1024,
    parameter [2:0] CAL_MODE    = 3'h3
) (
    input wire        CLK_SYS,         // System clock
    input wire        RST_N,           // Sync reset, active low
    input wire        PSEL,            // APB select
    input wire        PENABLE,         // APB access phase
    input wire        PWRITE,          // APB write
    input wire [11:0] PADDR,           // APB address
    input wire [31:0] PWDATA,          // APB write data
    input wire        PSLVERR,         // APB error
    input wire        SLOW_RC_CLK,     // Slow RC level
    input wire        SLOW_RC_EN,      // Slow RC enable
    input wire        FAST_RC_EN,      // Fast RC enable
    input wire        CRYSTAL_EN,      // Crystal enable
    input wire [7:0]  FAST_RC_TRIM,    // Fast RC trim
    input wire        WDT_EN,          // Watchdog enable
    input wire        BOOT_DONE,       // Boot wait over
    input wire        UNIT0_RUN,       // Unit 0 may fetch
    input wire        UNIT1_RUN,       // Unit 1 may fetch
    input wire [11:0] UNIT0_START_PC,  // Unit 0 start
    input wire [11:0] UNIT1_START_PC,  // Unit 1 start
    input wire        IRQ_REQ,         // Interrupt request
    input wire        UNIT0_INT_TAKE,  // Unit 0 takes interrupt
    input wire [11:0] UNIT0_INT_PC     // Interrupt vector
);
    logic [15:0] slow_cnt_r;
    logic        slow_prev_r;

    // Counts slow RC rising edges since reset
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            slow_cnt_r  <= 16'h0000;
            slow_prev_r <= 1'b0;
        end else begin
            slow_prev_r <= SLOW_RC_CLK;
            if (SLOW_RC_CLK && !slow_prev_r)
                slow_cnt_r <= slow_cnt_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    start_pc_a: assert property (UNIT0_START_PC == 12'h000 && UNIT1_START_PC == 12'h001)
        else $error("start address wrong");
    int_vector_a: assert property (UNIT0_INT_PC == 12'h010)
        else $error("interrupt vector wrong");
    int_take_a: assert property (UNIT0_INT_TAKE == (IRQ_REQ && UNIT0_RUN))
        else $error("interrupt take wrong");
    run_gate_a: assert property (!BOOT_DONE |-> !UNIT0_RUN && !UNIT1_RUN)
        else $error("unit runs before boot end");
    boot_count_a: assert property ($rose(BOOT_DONE) |-> slow_cnt_r == BOOT_CYCLES)
        else $error("boot wait length wrong");
    unit1_off_a: assert property ($rose(BOOT_DONE) |-> !UNIT1_RUN)
        else $error("unit 1 released at boot");
    boot_enables_a: assert property ($rose(BOOT_DONE) |-> SLOW_RC_EN && !CRYSTAL_EN
        && FAST_RC_EN == (CAL_MODE < 3'h5) && WDT_EN == (CAL_MODE >= 3'h5))
        else $error("enables wrong after boot");
    xtal_write_a: assert property ($changed(CRYSTAL_EN) |->
        $past(PSEL && PENABLE && PWRITE && PADDR == `OFS_XTAL_CTRL))
        else $error("crystal enable moved without write");
    trim_write_a: assert property (PSEL && PENABLE && PWRITE && PADDR == `OFS_TRIM && BOOT_DONE
        |=> FAST_RC_TRIM == $past(PWDATA[7:0]))
        else $error("trim not written");

    cover property ($rose(BOOT_DONE));
    cover property (UNIT0_INT_TAKE);
    cover property (PSLVERR);
    cover property (UNIT1_RUN);
endmodule

bind boot_clock_ctrl boot_clock_ctrl_chk #(.BOOT_CYCLES(BOOT_CYCLES), .CAL_MODE(CAL_MODE)) boot_clock_ctrl_chk_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR), .SLOW_RC_CLK(SLOW_RC_CLK),
    .SLOW_RC_EN(SLOW_RC_EN), .FAST_RC_EN(FAST_RC_EN), .CRYSTAL_EN(CRYSTAL_EN),
    .FAST_RC_TRIM(FAST_RC_TRIM), .WDT_EN(WDT_EN), .BOOT_DONE(BOOT_DONE), .UNIT0_RUN(UNIT0_RUN),
    .UNIT1_RUN(UNIT1_RUN), .UNIT0_START_PC(UNIT0_START_PC), .UNIT1_START_PC(UNIT1_START_PC),
    .IRQ_REQ(IRQ_REQ), .UNIT0_INT_TAKE(UNIT0_INT_TAKE), .UNIT0_INT_PC(UNIT0_INT_PC));
